// File: inc/ppfs_pkg.sv
// Purpose: Constants for the port pin function select block
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   Pin vector layout is {clk[4:0], twowire[1:0], c[3:0], analog[4:0], b[7:0]}
package ppfs_pkg;
  localparam int PIN_W   = 24;
  localparam int IRQ_N   = 6;
  localparam int AW      = 8;
  // Field positions inside the pin vector
  localparam int B_LSB   = 0;
  localparam int B_W     = 8;
  localparam int AN_LSB  = 8;
  localparam int AN_W    = 5;
  localparam int C_LSB   = 13;
  localparam int C_W     = 4;
  localparam int TW_LSB  = 17;
  localparam int TW_W    = 2;
  localparam int CK_LSB  = 19;
  localparam int CK_W    = 5;
  // Alternate input positions
  localparam int IRQ5_BIT  = 6;
  localparam int CNTA_BIT  = 7;
  localparam int CNTB_BIT  = 16;
  localparam int IRQ0_BIT  = 19;
  // Bits with a pull-up option, open-drain bits, analog bits
  localparam logic [PIN_W-1:0] PU_MASK  = 24'h09_E0FF;
  localparam logic [PIN_W-1:0] OD_MASK  = 24'h06_0000;
  localparam logic [PIN_W-1:0] AN_MASK  = 24'h00_1F00;
  // Reset values
  localparam logic [PIN_W-1:0] DIR_RST  = 24'hFF_FFFF;
  localparam logic [PIN_W-1:0] MODE_RST = 24'h00_1F00;
  localparam logic [PIN_W-1:0] ZERO_RST = 24'h00_0000;
  localparam logic [IRQ_N-1:0] IRQ_RST  = 6'h00;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_DIR    = 8'h00;
  localparam logic [AW-1:0] OFS_LATCH  = 8'h04;
  localparam logic [AW-1:0] OFS_MODE   = 8'h08;
  localparam logic [AW-1:0] OFS_PULLUP = 8'h0C;
  localparam logic [AW-1:0] OFS_PIN    = 8'h10;
  localparam logic [AW-1:0] OFS_RISE   = 8'h14;
  localparam logic [AW-1:0] OFS_FALL   = 8'h18;
  localparam logic [AW-1:0] OFS_STAT   = 8'h1C;
  localparam logic [AW-1:0] OFS_MASK   = 8'h20;
  localparam logic [AW-1:0] OFS_ALT    = 8'h24;
  // Alternate config register fields
  localparam int ALT_CAP_BIT   = 0;
  localparam int ALT_FLMD_BIT  = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: verilog/ppfs_edge_det.sv
// Purpose: Per-input valid edge detector for external interrupt requests
// Assumes: level is already synchronised to aclk
// Notes:   One-cycle pulse per selected edge, registered
`timescale 1ns/10ps
module ppfs_edge_det #(
  parameter int N = 6
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] level,
  input  wire logic [N-1:0] rise_en,
  input  wire logic [N-1:0] fall_en,
  output logic      [N-1:0] pulse
);
  logic [N-1:0] prev_ff;
  logic [N-1:0] pulse_ff;
  logic [N-1:0] nxt_pulse;

  if (N < 1) begin : g_chk
    $error("ppfs_edge_det: N must be at least 1");
  end

  genvar i;
  for (i = 0; i < N; i++) begin : g_bit
    // Rising, falling or both, per input
    assign nxt_pulse[i] = (rise_en[i] & level[i] & ~prev_ff[i]) |
                          (fall_en[i] & ~level[i] & prev_ff[i]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff  <= '0;
      pulse_ff <= '0;
    end else begin
      prev_ff  <= level;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse = pulse_ff;
endmodule // ppfs_edge_det

// File: verilog/ppfs_top.sv
// Purpose: Pin-level port logic with per-bit direction, pull-up and port/control selection
// Assumes: Single 125 MHz clock aclk, synchronous active-low aresetn, AXI4-Lite registers
// Notes:   Direction bit 1 means input; mode bit 1 selects the alternate control function
`timescale 1ns/10ps

// Operation
// - The eight-bit port has a direction bit per pin making it input or output.
// - Each bit of the eight-bit and four-bit ports has a software pull-up enable.
// - The five-bit analog-shared port has per-bit direction and no pull-up.
// - After reset all five analog-shared bits are in analog input mode.
// - The four-bit port has a direction bit per pin.
// - The two-bit serial-shared port has a direction bit per pin.
// - The two-bit port only ever drives low and otherwise releases the pin.
// - The five-bit clock-shared port has a direction bit per pin.
// - Only the lowest bit of the clock-shared port has a pull-up option.
// - Each external interrupt input fires on rising, falling or both edges as set.
// - Port mode or control function is chosen separately for every pin.
// - The capture trigger pin feeds the first sixteen-bit timer capture when selected.
// - Each count clock pin feeds its eight-bit timer as count clock when selected.
// - The system reset is active low and holds the block in reset while low.
module ppfs_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [ppfs_pkg::AW-1:0]       s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ppfs_pkg::AW-1:0]       s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [ppfs_pkg::PIN_W-1:0]    pin_in,
  output logic      [ppfs_pkg::PIN_W-1:0]    pin_out,
  output logic      [ppfs_pkg::PIN_W-1:0]    pin_oe_n,
  output logic      [ppfs_pkg::PIN_W-1:0]    pullup_en,
  output logic      [ppfs_pkg::AN_W-1:0]     analog_sel,
  input  wire logic [ppfs_pkg::PIN_W-1:0]    alt_out,
  input  wire logic [ppfs_pkg::PIN_W-1:0]    alt_oe,
  input  wire logic                          capture_trigger_in,
  input  wire logic                          flash_prog_mode_pin,
  output logic                               capture_trig_out,
  output logic                               count_clk_a_out,
  output logic                               count_clk_b_out,
  output logic      [ppfs_pkg::IRQ_N-1:0]    ext_irq_req,
  output logic                               irq
);
  import ppfs_pkg::*;

  // Register file
  logic [PIN_W-1:0] dir_ff, latch_ff, mode_ff, pullup_ff;
  logic [IRQ_N-1:0] rise_ff, fall_ff, stat_ff, mask_ff;
  logic             cap_en_ff;
  // AXI handshake state
  logic             wr_rdy_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]       bresp_ff, rresp_ff;
  logic [31:0]      rdata_ff;
  // Synchronisers and outputs
  logic [PIN_W-1:0] pin_s1_ff, pin_s2_ff;
  logic             cap_s1_ff, cap_s2_ff, flmd_s1_ff, flmd_s2_ff;
  logic [PIN_W-1:0] pin_out_ff, pin_oe_n_ff, pullup_en_ff;
  logic [AN_W-1:0]  analog_sel_ff;
  logic             cap_out_ff, cnta_ff, cntb_ff, irq_ff;
  logic [PIN_W-1:0] nxt_pin_out, nxt_oe_n, nxt_pullup;
  logic [IRQ_N-1:0] irq_level, irq_pulse, irq_ev, nxt_stat;

  // Named per-port views of the combined registers
  wire [B_W-1:0]  dir_reg_port_b       = dir_ff[B_LSB +: B_W];
  wire [B_W-1:0]  pullup_reg_port_b    = pullup_ff[B_LSB +: B_W];
  wire [AN_W-1:0] dir_reg_port_analog  = dir_ff[AN_LSB +: AN_W];
  wire [C_W-1:0]  dir_reg_port_c       = dir_ff[C_LSB +: C_W];
  wire [C_W-1:0]  pullup_reg_port_c    = pullup_ff[C_LSB +: C_W];
  wire [TW_W-1:0] dir_reg_port_twowire = dir_ff[TW_LSB +: TW_W];
  wire [CK_W-1:0] dir_reg_port_clk     = dir_ff[CK_LSB +: CK_W];
  wire            pullup_reg_port_clk  = pullup_ff[CK_LSB];
  wire            clk_port_bit0        = pin_s2_ff[CK_LSB];

  wire [PIN_W-1:0] dir_all    = {dir_reg_port_clk, dir_reg_port_twowire, dir_reg_port_c,
                                 dir_reg_port_analog, dir_reg_port_b};
  wire [PIN_W-1:0] pu_all     = {{(CK_W-1){1'b0}}, pullup_reg_port_clk, {TW_W{1'b0}},
                                 pullup_reg_port_c, {AN_W{1'b0}}, pullup_reg_port_b};

  // Write channel decode
  wire wr_go    = s_axi_awvalid & s_axi_wvalid & wr_rdy_ff;
  wire wr_dir   = wr_go & (s_axi_awaddr == OFS_DIR);
  wire wr_latch = wr_go & (s_axi_awaddr == OFS_LATCH);
  wire wr_mode  = wr_go & (s_axi_awaddr == OFS_MODE);
  wire wr_pu    = wr_go & (s_axi_awaddr == OFS_PULLUP);
  wire wr_rise  = wr_go & (s_axi_awaddr == OFS_RISE);
  wire wr_fall  = wr_go & (s_axi_awaddr == OFS_FALL);
  wire wr_mask  = wr_go & (s_axi_awaddr == OFS_MASK);
  wire wr_alt   = wr_go & (s_axi_awaddr == OFS_ALT);
  wire wr_hit   = wr_dir | wr_latch | wr_mode | wr_pu | wr_rise | wr_fall | wr_mask | wr_alt |
                  (s_axi_awaddr == OFS_PIN) | (s_axi_awaddr == OFS_STAT);
  wire nxt_wr_rdy = s_axi_awvalid & s_axi_wvalid & ~wr_rdy_ff & ~bvalid_ff;

  // Byte-lane merge of write data into a stored value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (s[k]) begin
        r[k*8 +: 8] = d[k*8 +: 8];
      end
    end
    return r;
  endfunction

  wire [31:0] m_dir   = wmerge({8'h00, dir_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] m_latch = wmerge({8'h00, latch_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] m_mode  = wmerge({8'h00, mode_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] m_pu    = wmerge({8'h00, pullup_ff}, s_axi_wdata, s_axi_wstrb);
  wire [31:0] m_rise  = wmerge(32'(rise_ff), s_axi_wdata, s_axi_wstrb);
  wire [31:0] m_fall  = wmerge(32'(fall_ff), s_axi_wdata, s_axi_wstrb);
  wire [31:0] m_mask  = wmerge(32'(mask_ff), s_axi_wdata, s_axi_wstrb);
  wire [31:0] m_alt   = wmerge(32'(cap_en_ff), s_axi_wdata, s_axi_wstrb);

  // Read channel decode
  wire rd_go   = s_axi_arvalid & arready_ff;
  wire rd_clr  = rd_go & (s_axi_araddr == OFS_STAT);
  wire [31:0] pin_rd = {8'h00, pin_s2_ff & ~(mode_ff & AN_MASK)};
  wire [31:0] alt_rd = {23'h0, flmd_s2_ff, 7'h0, cap_en_ff};
  wire rd_hit  = (s_axi_araddr == OFS_DIR) | (s_axi_araddr == OFS_LATCH) |
                 (s_axi_araddr == OFS_MODE) | (s_axi_araddr == OFS_PULLUP) |
                 (s_axi_araddr == OFS_PIN) | (s_axi_araddr == OFS_RISE) |
                 (s_axi_araddr == OFS_FALL) | (s_axi_araddr == OFS_STAT) |
                 (s_axi_araddr == OFS_MASK) | (s_axi_araddr == OFS_ALT);
  wire [31:0] rd_mux =
      (s_axi_araddr == OFS_DIR)    ? {8'h00, dir_all} :
      (s_axi_araddr == OFS_LATCH)  ? {8'h00, latch_ff} :
      (s_axi_araddr == OFS_MODE)   ? {8'h00, mode_ff} :
      (s_axi_araddr == OFS_PULLUP) ? {8'h00, pu_all} :
      (s_axi_araddr == OFS_PIN)    ? pin_rd :
      (s_axi_araddr == OFS_RISE)   ? 32'(rise_ff) :
      (s_axi_araddr == OFS_FALL)   ? 32'(fall_ff) :
      (s_axi_araddr == OFS_STAT)   ? 32'(stat_ff) :
      (s_axi_araddr == OFS_MASK)   ? 32'(mask_ff) :
      (s_axi_araddr == OFS_ALT)    ? alt_rd : 32'h0000_0000;

  // Per-pin output, enable and pull-up selection
  genvar g;
  for (g = 0; g < PIN_W; g++) begin : g_pin
    wire ctrl   = mode_ff[g];
    wire is_an  = AN_MASK[g] & ctrl;
    wire drive  = is_an ? 1'b0 : (ctrl ? alt_oe[g] : ~dir_all[g]);
    wire value  = ctrl ? alt_out[g] : latch_ff[g];
    if (OD_MASK[g]) begin : g_od
      assign nxt_pin_out[g] = 1'b0;
      assign nxt_oe_n[g]    = ~(drive & ~value);
    end else begin : g_pp
      assign nxt_pin_out[g] = value;
      assign nxt_oe_n[g]    = ~drive;
    end
    assign nxt_pullup[g] = PU_MASK[g] & pu_all[g] & ~drive;
  end

  // External interrupt sources, gated by control mode
  assign irq_level = {pin_s2_ff[IRQ5_BIT], pin_s2_ff[C_LSB +: C_W], clk_port_bit0};
  wire [IRQ_N-1:0] irq_sel = {mode_ff[IRQ5_BIT], mode_ff[C_LSB +: C_W], mode_ff[IRQ0_BIT]};

  ppfs_edge_det #(
    .N (IRQ_N)
  ) u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (irq_level),
    .rise_en (rise_ff & irq_sel),
    .fall_en (fall_ff & irq_sel),
    .pulse   (irq_pulse)
  );

  // Mode gating sits ahead of the edge flop so the request output is a register
  assign irq_ev   = irq_pulse;
  // Set wins over the clear-on-read
  assign nxt_stat = (rd_clr ? IRQ_RST : stat_ff) | irq_ev;

  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff  <= ZERO_RST;
      pin_s2_ff  <= ZERO_RST;
      cap_s1_ff  <= 1'b0;
      cap_s2_ff  <= 1'b0;
      flmd_s1_ff <= 1'b0;
      flmd_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff  <= pin_in;
      pin_s2_ff  <= pin_s1_ff;
      cap_s1_ff  <= capture_trigger_in;
      cap_s2_ff  <= cap_s1_ff;
      flmd_s1_ff <= flash_prog_mode_pin;
      flmd_s2_ff <= flmd_s1_ff;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_ff    <= DIR_RST;
      latch_ff  <= ZERO_RST;
      mode_ff   <= MODE_RST;
      pullup_ff <= ZERO_RST;
      rise_ff   <= IRQ_RST;
      fall_ff   <= IRQ_RST;
      mask_ff   <= IRQ_RST;
      cap_en_ff <= 1'b0;
    end else begin
      if (wr_dir)   dir_ff    <= m_dir[PIN_W-1:0];
      if (wr_latch) latch_ff  <= m_latch[PIN_W-1:0];
      if (wr_mode)  mode_ff   <= m_mode[PIN_W-1:0];
      if (wr_pu)    pullup_ff <= m_pu[PIN_W-1:0] & PU_MASK;
      if (wr_rise)  rise_ff   <= m_rise[IRQ_N-1:0];
      if (wr_fall)  fall_ff   <= m_fall[IRQ_N-1:0];
      if (wr_mask)  mask_ff   <= m_mask[IRQ_N-1:0];
      if (wr_alt)   cap_en_ff <= m_alt[ALT_CAP_BIT];
    end
  end

  // AXI4-Lite write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_rdy_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else begin
      wr_rdy_ff <= nxt_wr_rdy;
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // AXI4-Lite read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // Interrupt status and pin-facing outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff       <= IRQ_RST;
      irq_ff        <= 1'b0;
      pin_out_ff    <= ZERO_RST;
      pin_oe_n_ff   <= DIR_RST;
      pullup_en_ff  <= ZERO_RST;
      analog_sel_ff <= MODE_RST[AN_LSB +: AN_W];
      cap_out_ff    <= 1'b0;
      cnta_ff       <= 1'b0;
      cntb_ff       <= 1'b0;
    end else begin
      stat_ff       <= nxt_stat;
      irq_ff        <= |(nxt_stat & mask_ff);
      pin_out_ff    <= nxt_pin_out;
      pin_oe_n_ff   <= nxt_oe_n;
      pullup_en_ff  <= nxt_pullup;
      analog_sel_ff <= mode_ff[AN_LSB +: AN_W];
      cap_out_ff    <= cap_en_ff & cap_s2_ff;
      cnta_ff       <= mode_ff[CNTA_BIT] & pin_s2_ff[CNTA_BIT];
      cntb_ff       <= mode_ff[CNTB_BIT] & pin_s2_ff[CNTB_BIT];
    end
  end

  assign s_axi_awready    = wr_rdy_ff;
  assign s_axi_wready     = wr_rdy_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_arready    = arready_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rdata      = rdata_ff;
  assign s_axi_rresp      = rresp_ff;
  assign pin_out          = pin_out_ff;
  assign pin_oe_n         = pin_oe_n_ff;
  assign pullup_en        = pullup_en_ff;
  assign analog_sel       = analog_sel_ff;
  assign capture_trig_out = cap_out_ff;
  assign count_clk_a_out  = cnta_ff;
  assign count_clk_b_out  = cntb_ff;
  assign ext_irq_req      = irq_ev;
  assign irq              = irq_ff;
endmodule // ppfs_top

// File: bench/ppfs_asserts.sv
// Purpose: Port-level assertions for the pin function select block
// Assumes: One clock aclk, synchronous active-low aresetn
// Notes:   Bound into every ppfs_top instance
`timescale 1ns/10ps
module ppfs_asserts (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [ppfs_pkg::PIN_W-1:0] pin_in,
  input wire logic [ppfs_pkg::PIN_W-1:0] pin_out,
  input wire logic [ppfs_pkg::PIN_W-1:0] pin_oe_n,
  input wire logic [ppfs_pkg::PIN_W-1:0] pullup_en,
  input wire logic [ppfs_pkg::AN_W-1:0]  analog_sel,
  input wire logic                       capture_trigger_in,
  input wire logic                       capture_trig_out,
  input wire logic                       count_clk_a_out,
  input wire logic                       count_clk_b_out,
  input wire logic [ppfs_pkg::IRQ_N-1:0] ext_irq_req
);
  import ppfs_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  od_low_a: assert property (pin_out[TW_LSB +: TW_W] == 2'h0)
    else $error("open-drain pin driven high");
  pullup_allow_a: assert property ((pullup_en & ~PU_MASK) == ZERO_RST)
    else $error("pull-up on a pin without the option");
  pullup_float_a: assert property ((pullup_en & ~pin_oe_n) == ZERO_RST)
    else $error("pull-up on a driven pin");
  reset_state_a: assert property ($rose(aresetn) |-> pin_oe_n == DIR_RST && analog_sel == 5'h1F)
    else $error("pins not released or not analog after reset");
  analog_off_a: assert property ((analog_sel & ~pin_oe_n[AN_LSB +: AN_W]) == 5'h00)
    else $error("analog pin driven");
  cap_route_a: assert property (capture_trig_out |-> $past(capture_trigger_in, 3))
    else $error("capture trigger without its pin");
  cnt_a_route_a: assert property (count_clk_a_out |-> $past(pin_in[CNTA_BIT], 3))
    else $error("count clock a without its pin");
  cnt_b_route_a: assert property (count_clk_b_out |-> $past(pin_in[CNTB_BIT], 3))
    else $error("count clock b without its pin");
  irq_cause_a: assert property (ext_irq_req[0] |-> $past(pin_in[IRQ0_BIT], 3) != $past(pin_in[IRQ0_BIT], 4))
    else $error("interrupt request without a pin edge");
  irq_pulse_a: assert property (|ext_irq_req |=> (ext_irq_req & $past(ext_irq_req)) == IRQ_RST ||
                                $past(pin_in, 3) != $past(pin_in, 4))
    else $error("interrupt request longer than one cycle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  aw_pulse_a: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
    else $error("address and data ready disagree");
endmodule // ppfs_asserts
bind ppfs_top ppfs_asserts i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pullup_en(pullup_en), .analog_sel(analog_sel), .capture_trigger_in(capture_trigger_in),
  .capture_trig_out(capture_trig_out), .count_clk_a_out(count_clk_a_out),
  .count_clk_b_out(count_clk_b_out), .ext_irq_req(ext_irq_req));

// File: bench/ppfs_pad_model.sv
// Purpose: Board-side pads around the pin block
// Assumes: Block output wins over an outside driver
// Notes:   Undriven pins without a pull-up toggle every cycle, except open-drain pins, which read high
`timescale 1ns/10ps
module ppfs_pad_model (
  input  wire logic                       aclk,
  input  wire logic [ppfs_pkg::PIN_W-1:0] pin_out,
  input  wire logic [ppfs_pkg::PIN_W-1:0] pin_oe_n,
  input  wire logic [ppfs_pkg::PIN_W-1:0] pullup_en,
  input  wire logic [ppfs_pkg::PIN_W-1:0] ext_val,
  input  wire logic [ppfs_pkg::PIN_W-1:0] ext_drv,
  input  wire logic                       prog_req,
  output logic      [ppfs_pkg::PIN_W-1:0] pin_in,
  output logic                            flash_prog_mode_pin
);
  import ppfs_pkg::*;
  logic [PIN_W-1:0] float_ff = 24'h55_5555;
  always_ff @(posedge aclk) float_ff <= ~float_ff;
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_drv[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i] || OD_MASK[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_ff[i];
    end
  end
  // Held at ground except when programming is asked for
  assign flash_prog_mode_pin = prog_req;
endmodule // ppfs_pad_model

// File: bench/ppfs_top_test.sv
// Purpose: Self-checking bench for the pin function select block
// Assumes: 125 MHz aclk, AXI4-Lite master tasks, pad model on the pins
// Notes:   Register and pin model kept in mdl, indexed by word offset
`timescale 1ns/10ps
module ppfs_top_test;
  import ppfs_pkg::*;
  logic             aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic             arvalid = 0, rready = 0, cap_in = 0, prog = 0, flash;
  logic             awready, wready, bvalid, arready, rvalid, cap_out, cnt_a, cnt_b, irq;
  logic [AW-1:0]    awaddr = '0, araddr = '0;
  logic [31:0]      wdata = '0, rdata, mdl [11];
  logic [1:0]       bresp, rresp;
  logic [PIN_W-1:0] pin_in, pin_out, oe_n, pu, alt_out = '0, alt_oe = '0, ext_val = '0, ext_drv = '0;
  logic [AN_W-1:0]  an_sel;
  logic [IRQ_N-1:0] ext_irq;
  int               n_fail = 0, compares = 0, cyc = 0, p0, pc [IRQ_N] = '{default: 0};
  int               sp [IRQ_N] = '{IRQ0_BIT, 13, 14, 15, 16, IRQ5_BIT};
  ppfs_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(oe_n), .pullup_en(pu), .analog_sel(an_sel), .alt_out(alt_out),
    .alt_oe(alt_oe), .capture_trigger_in(cap_in), .flash_prog_mode_pin(flash),
    .capture_trig_out(cap_out), .count_clk_a_out(cnt_a), .count_clk_b_out(cnt_b),
    .ext_irq_req(ext_irq), .irq(irq));
  ppfs_pad_model i_pads (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(oe_n), .pullup_en(pu),
    .ext_val(ext_val), .ext_drv(ext_drv), .prog_req(prog), .pin_in(pin_in), .flash_prog_mode_pin(flash));
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    for (int i = 0; i < IRQ_N; i++) if (ext_irq[i] === 1'b1) pc[i]++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wchk(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
    case (a / 4)
      0, 1, 2: mdl[a / 4] = d & 32'h00FF_FFFF;
      3: mdl[3] = d & 32'(PU_MASK);
      5, 6, 8: mdl[a / 4] = d & 32'h0000_003F;
      9: mdl[9] = d & 32'h0000_0001;
      default: ;
    endcase
    @(posedge aclk);
  endtask
  task automatic rc(input logic [AW-1:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk("rdata", e & m, rdata & m);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic chk_pins();
    logic [PIN_W-1:0] eo, ev, lv, kn, pe, an;
    an = mdl[2][PIN_W-1:0] & AN_MASK;
    for (int i = 0; i < PIN_W; i++) begin
      ev[i] = mdl[2][i] ? alt_out[i] : mdl[1][i];
      eo[i] = !mdl[2][i] ? mdl[0][i] : AN_MASK[i] ? 1'b1 : !alt_oe[i];
      eo[i] = eo[i] | (OD_MASK[i] & ev[i]);
      pe[i] = mdl[3][i] & eo[i];
      lv[i] = !eo[i] ? ev[i] & !OD_MASK[i] : ext_drv[i] ? ext_val[i] : 1'b1;
      kn[i] = !eo[i] | ext_drv[i] | pe[i] | OD_MASK[i];
    end
    chk("pin_oe_n", 32'(eo), 32'(oe_n));
    chk("pin_out", 32'(ev & ~eo & ~OD_MASK), 32'(pin_out & ~eo));
    chk("pullup_en", 32'(pe), 32'(pu));
    chk("analog_sel", 32'(mdl[2][12:8]), 32'(an_sel));
    rc(OFS_PIN, 32'(lv & ~an), 32'(kn | an), RESP_OKAY);
  endtask
  initial begin
    mdl = '{32'h00FF_FFFF, 0, 32'h0000_1F00, 0, 0, 0, 0, 0, 0, 0, 0};
    void'($urandom(67));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_pins();
    for (int a = 0; a < 11; a++) if (a != 4) rc(8'(4 * a), mdl[a], 32'hFFFF_FFFF, a == 10 ? RESP_SLVERR : RESP_OKAY);
    wchk(OFS_PIN, 32'hFFFF_FFFF, RESP_OKAY);
    wchk(OFS_STAT, 32'hFFFF_FFFF, RESP_OKAY);
    wchk(8'h28, 32'hFFFF_FFFF, RESP_SLVERR);
    for (int k = 0; k < 40; k++) begin
      alt_out <= 24'($urandom);
      alt_oe <= 24'($urandom);
      ext_val <= 24'($urandom);
      ext_drv <= 24'($urandom);
      for (int a = 0; a < 4; a++) wchk(8'(4 * a), $urandom, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk_pins();
      for (int a = 0; a < 5; a++) if (a != 4) rc(8'(4 * a), mdl[a], 32'hFFFF_FFFF, RESP_OKAY);
    end
    alt_oe <= '0;
    ext_drv <= '1;
    ext_val <= '0;
    wchk(OFS_DIR, 32'h00FF_FFFF, RESP_OKAY);
    wchk(OFS_MODE, 32'h0009_E040, RESP_OKAY);
    for (int m = 1; m < 4; m++) begin
      for (int s = 0; s < IRQ_N; s++) begin
        wchk(OFS_RISE, m[0] ? 1 << s : 0, RESP_OKAY);
        wchk(OFS_FALL, m[1] ? 1 << s : 0, RESP_OKAY);
        wchk(OFS_MASK, s % 2 ? 1 << s : ~(1 << s), RESP_OKAY);
        p0 = pc[s];
        ext_val[sp[s]] <= 1'b1;
        repeat (8) @(posedge aclk);
        ext_val[sp[s]] <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("irq pulses", m[0] + m[1], pc[s] - p0);
        chk("irq", s % 2, 32'(irq));
        rc(OFS_STAT, 1 << s, 32'hFFFF_FFFF, RESP_OKAY);
        rc(OFS_STAT, 0, 32'hFFFF_FFFF, RESP_OKAY);
        chk("irq", 0, 32'(irq));
      end
    end
    for (int e = 0; e < 2; e++) begin
      wchk(OFS_MODE, e ? 32'h0001_0080 : 0, RESP_OKAY);
      wchk(OFS_ALT, e, RESP_OKAY);
      prog <= e[0];
      cap_in <= 1'b1;
      ext_val <= '1;
      repeat (5) @(posedge aclk);
      chk("capture", e, 32'(cap_out));
      chk("count a", e, 32'(cnt_a));
      chk("count b", e, 32'(cnt_b));
      rc(OFS_ALT, e | e << ALT_FLMD_BIT, 32'hFFFF_FFFF, RESP_OKAY);
      cap_in <= 1'b0;
      ext_val <= '0;
      prog <= 1'b0;
      repeat (5) @(posedge aclk);
      chk("capture", 0, 32'(cap_out));
      chk("count a", 0, 32'(cnt_a));
    end
    give_verdict();
  end
endmodule // ppfs_top_test
